// ===== inc/flash_host_pkg.sv
package flash_host_pkg;
  // ==========================================================
  // avalon register map of the controller (byte addresses)
  localparam logic [3:0] reg_cmd = 4'h0;
  localparam logic [3:0] reg_addr = 4'h4;
  localparam logic [3:0] reg_data = 4'h8;
  localparam logic [3:0] reg_status = 4'hc;
  // ==========================================================
  // command codes written to reg_cmd[2:0]
  localparam logic [2:0] op_read = 3'h1;
  localparam logic [2:0] op_write = 3'h2;
  localparam logic [2:0] op_toggle_poll = 3'h3;
  localparam logic [2:0] op_data_poll = 3'h4;
  // ==========================================================
  // status bit positions on the low data lines
  localparam int polled_data_pos = 7;
  localparam int first_toggle_pos = 6;
  localparam int timeout_error_pos = 5;
  localparam int erase_start_pos = 3;
  localparam int second_toggle_pos = 2;
  // ==========================================================
  // reset values and bus timing
  localparam logic [7:0] reset_command = 8'hf0;
  localparam int strobe_ns = 100;
  localparam int clk_ns = 50;
  localparam int strobe_cycles = (strobe_ns + clk_ns - 1) / clk_ns;
  // ==========================================================
  // poll outcomes
  typedef enum logic [1:0] {res_none, res_done, res_fail} poll_result_t;
  typedef struct packed {
    logic busy;
    poll_result_t result;
    logic second_toggled;
    logic suspended_view;
    logic [7:0] last_data;
  } host_status_t;
endpackage

// ===== rtl/flash_host.sv
`timescale 1ns/1ps
// Summary of operation
// RL1: device takes erase-suspend only during sector erase; host just writes it
// RL2: suspend completes within 20 us; software polls after writing it
// RL3: suspended device allows reads and programs in non-erasing sectors
// RL4: reads inside suspended sectors return status on all low data lines
// RL5: identification sequence unsupported while suspended
// RL6: resume command written at any address restarts the sector erase
// RL7: polled data bit reads inverted until programming ends
// RL8: polled data bit reads 0 while erasing, 1 after
// RL9: polling address must lie in the busy, unprotected sector
// RL10: after polled bit turns valid, take data from another read
// RL11: ready/busy output low while programming or erasing
// RL12: first toggle bit flips on each read during program or erase
// RL13: protected program toggles about 2 us then stops
// RL14: fully protected erase toggles about 100 us then returns to read
// RL15: timeout error bit high means the operation failed
// RL16: after failure the host writes the reset command
// RL17: on error bit, recheck toggling before declaring failure
// RL18: erase-start flag rises once sector erase begins
// RL19: second toggle bit flips on reads in erase-selected sectors
// RL20: combine both toggle bits to tell selected sector and suspend
// RL21: read status twice and compare; no toggle means complete
// RL22: on toggling check error bit, recheck, reset on failure
// RL23: first toggle bit steady once done or suspend acknowledged
module flash_host
  import flash_host_pkg::*;
#(
  parameter int addr_w = 20
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [addr_w-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic flash_ready_busy_n
);
  // ==========================================================
  // bus cycle engine
  typedef enum {st_idle, st_rd, st_wr, st_eval, st_reset_wr} state_t;
  localparam int cnt_w = $clog2(strobe_cycles + 1);
  localparam logic [cnt_w-1:0] strobe_load = cnt_w'(strobe_cycles);
  state_t state;
  logic [cnt_w-1:0] cnt;
  logic [2:0] op;
  logic [addr_w-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] prev;
  logic [1:0] reads;
  logic err_seen;
  logic [7:0] expect_data;
  host_status_t st;
  logic strobe_done;
  logic wr_take;
  assign strobe_done = (cnt == 0);
  // a write lands only on its answer edge; a request held past it is taken again two cycles later
  assign wr_take = avs_write && !avs_waitrequest;

  // one flash cycle at a time; software sequences unlock, suspend and resume
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= st_idle;
      cnt <= '0;
      op <= 3'h0;
      addr <= '0;
      wdata <= 8'h00;
      expect_data <= 8'h00;
      prev <= 8'h00;
      reads <= 2'h0;
      err_seen <= 1'b0;
      st <= '0;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      case (state)
        st_idle: begin
          if (wr_take && avs_address == reg_addr) begin
            addr <= avs_writedata[addr_w-1:0];
          end
          if (wr_take && avs_address == reg_data) begin
            wdata <= avs_writedata[7:0];
            expect_data <= avs_writedata[7:0];
          end
          // commands arriving while busy are ignored: the engine is not idle then
          if (wr_take && avs_address == reg_cmd && avs_writedata[2:0] != 3'h0) begin
            op <= avs_writedata[2:0];
            st.busy <= 1'b1;
            st.result <= res_none;
            reads <= 2'h0;
            err_seen <= 1'b0;
            st.second_toggled <= 1'b0;
            // suspend/resume/unlock are plain writes issued in order by software [RL1] [RL6]
            state <= (avs_writedata[2:0] == op_write) ? st_wr : st_rd;
            flash_addr <= addr; // software points polls at the busy sector [RL9]
            flash_ce_n <= 1'b0;
            cnt <= strobe_load;
            if (avs_writedata[2:0] == op_write) begin
              flash_dq_out <= wdata;
              flash_dq_oe <= 1'b1;
              flash_we_n <= 1'b0;
            end else begin
              flash_oe_n <= 1'b0;
            end
          end
        end
        st_rd: begin
          if (strobe_done) begin
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            st.last_data <= flash_dq_in; // status or array per sector [RL4] [RL3]
            prev <= flash_dq_in;
            reads <= reads + 2'h1;
            if (reads != 2'h0 && flash_dq_in[second_toggle_pos] != prev[second_toggle_pos]) begin
              st.second_toggled <= 1'b1; // sector selected for erase [RL19] [RL20]
            end
            state <= st_eval;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        st_wr: begin
          // no read-back after a write: software polls the device for completion
          if (strobe_done) begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            st.busy <= 1'b0;
            state <= st_idle;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        st_eval: begin
          state <= st_rd;
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b0;
          cnt <= strobe_load;
          if (op == op_read) begin
            st.busy <= 1'b0;
            state <= st_idle;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
          end else if (op == op_data_poll) begin
            if (prev[polled_data_pos] == expect_data[polled_data_pos]) begin
              // polled bit valid; one more read for the other lines [RL7] [RL8] [RL10]
              op <= op_read;
              st.result <= res_done;
            end else if (prev[timeout_error_pos]) begin
              op <= op_toggle_poll; // recheck via toggle before failing [RL15] [RL17]
              reads <= 2'h0;
              err_seen <= 1'b1;
            end
          end else if (reads >= 2'h2) begin
            // compare two consecutive reads of the first toggle bit [RL21] [RL12] [RL23]
            if (st.last_data[first_toggle_pos] == st.suspended_view) begin
              st.result <= res_done;
              op <= op_read;
            end else if (err_seen) begin
              state <= st_reset_wr; // still toggling after error [RL16] [RL22]
              flash_oe_n <= 1'b1;
              flash_dq_out <= reset_command;
              flash_dq_oe <= 1'b1;
              flash_we_n <= 1'b0;
            end else if (prev[timeout_error_pos]) begin
              err_seen <= 1'b1; // error seen: one more comparison [RL17] [RL22]
            end
          end
          // keep this read's toggle bit; the next evaluation compares against it
          st.suspended_view <= prev[first_toggle_pos];
        end
        st_reset_wr: begin
          if (strobe_done) begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            st.result <= res_fail;
            st.busy <= 1'b0;
            state <= st_idle;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle on every access
  // waitrequest is its own flop so the answer comes straight from a register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      case (avs_address)
        reg_addr: avs_readdata <= 32'(addr);
        reg_data: avs_readdata <= {24'h000000, wdata};
        // ready_busy level shown for software waits [RL11] [RL2] [RL13] [RL14] [RL18]
        reg_status: avs_readdata <= {19'h00000, !flash_ready_busy_n, st.busy, st.result,
          st.second_toggled, st.last_data};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // flash_host

// ===== sim/flash_host_checker.sv
`timescale 1ns/1ps
// ====================
// strobe and bus checks
module flash_host_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence we_pulse; !flash_we_n [*2]; endsequence
  sequence oe_pulse; !flash_oe_n [*2]; endsequence
  strobe_excl_a: assert property (flash_oe_n || flash_we_n) else $error("oe and we low");
  wr_width_a: assert property ($fell(flash_we_n) |-> we_pulse) else $error("short write");
  rd_width_a: assert property ($fell(flash_oe_n) |-> oe_pulse) else $error("short read");
  wr_drive_a: assert property (!flash_we_n |-> flash_dq_oe) else $error("write undriven");
  rd_release_a: assert property (!flash_oe_n |-> !flash_dq_oe) else $error("read clash");
  chip_sel_a: assert property (!(flash_oe_n && flash_we_n) |-> !flash_ce_n)
    else $error("strobe without select");
  wr_hold_a: assert property (!flash_we_n && $past(!flash_we_n) |-> $stable(flash_dq_out))
    else $error("write data moved");
  ack_bound_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("late answer");
endmodule // flash_host_checker
bind flash_host flash_host_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n));

// ===== sim/flash_dev_model.sv
`timescale 1ns/1ps
// ====================
// one-sector device; busy time counted in reads since it has no clock
module flash_dev_model (
  input wire logic [7:0] dq_out,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic prot,
  output logic [7:0] dq_in,
  output logic rb_low
);
  logic [7:0] mem = 8'hff, pd = 8'h0, last = 8'h0, wd = 8'h0, val;
  logic arm = 0, tg = 0, t2 = 0, err = 0, susp = 0;
  int prog = 0, ers = 0;
  assign val = prog != 0 ? {~pd[7], tg, err, 5'h0}
    : ers != 0 ? {susp, tg, 3'b001, t2, 2'h0} : mem;
  // no pull-up on data: released lines show the inverse of the last byte
  assign dq_in = (!ce_n && !oe_n) ? val : ~last;
  assign rb_low = prog != 0 || (ers != 0 && !susp);
  always @(dq_out or we_n) if (!we_n) wd = dq_out;
  always @(posedge oe_n) begin
    last = val;
    if (prog != 0 || (ers != 0 && !susp)) tg = ~tg;
    if (ers != 0) t2 = ~t2;
    if (prog > 1 && !err) prog--;
    else if (prog == 1 && !err) begin
      prog = 0;
      if (!prot) mem = pd; // a protected byte toggles a while, then keeps its data
    end
    if (ers == 1 && !susp && !prot) mem = 8'hff; // an unprotected erase ends with all ones
    if (ers > 0 && !susp) ers--;
  end
  always @(posedge we_n) begin
    if (arm) begin
      arm = 0;
      pd = wd;
      prog = 6;
      err = (wd & ~mem) != 8'h0; // a 1 over a 0 never completes
    end else case (wd)
      8'ha0: arm = 1;
      8'h30: if (susp) susp = 0; else if (ers == 0) ers = 6;
      8'hb0: if (ers != 0) susp = 1;
      8'hf0: if (err) {err, prog} = '0;
      default: ;
    endcase
  end
endmodule // flash_dev_model

// ===== sim/tb_flash_host.sv
`timescale 1ns/1ps
module tb_flash_host;
  import flash_host_pkg::*;
  logic clk_sys = 0, rstn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, prot = 0;
  logic dq_oe, ce_n, oe_n, we_n, rb;
  logic [19:0] fa;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [7:0] dq_out, dq_in;
  int n_mismatch = 0, compares = 0;
  flash_host u_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(fa),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_ready_busy_n(!rb));
  flash_dev_model u_mem (.dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_in),
    .rb_low(rb), .prot(prot));
  initial forever #25 clk_sys = ~clk_sys;
  // ====================
  // bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic op(input logic [2:0] c);
    acc(1'b1, reg_cmd, {29'h0, c});
    do acc(1'b0, reg_status, 32'h0); while (rd[11] !== 1'b0);
  endtask
  task automatic cyc(input logic [7:0] b);
    acc(1'b1, reg_addr, 32'h0);
    acc(1'b1, reg_data, {24'h0, b});
    op(op_write);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_program;
    cyc(8'ha0);
    cyc(8'h5a);
    chk(rd[12], 32'h1);
    op(op_toggle_poll);
    chk(rd[10:9], 32'h1);
    op(op_read);
    chk(rd[7:0], 32'h5a);
  endtask
  task automatic t_data_poll;
    cyc(8'ha0);
    cyc(8'h12);
    acc(1'b1, reg_addr, 32'h12345);
    op(op_data_poll);
    chk(fa, 32'h12345);
    chk(rd[10:9], 32'h1);
    op(op_read);
    chk(rd[7:0], 32'h12);
  endtask
  task automatic t_fail;
    cyc(8'ha0);
    cyc(8'hff);
    op(op_toggle_poll);
    chk(rd[10:9], 32'h2);
    chk(u_mem.err, 32'h0);
    op(op_read);
    chk(rd[7:0], 32'h12);
  endtask
  task automatic t_suspend;
    cyc(8'h30);
    cyc(8'hb0);
    chk(rd[12], 32'h0);
    op(op_toggle_poll);
    chk(rd[10:8], 32'h3);
    chk(rd[7], 32'h1);
    cyc(8'h30);
    cyc(8'h30);
    acc(1'b1, reg_data, 32'hff);
    op(op_data_poll);
    chk(rd[10:9], 32'h1);
    op(op_read);
    chk(rd[7:0], 32'hff);
  endtask
  task automatic t_protect;
    prot <= 1'b1;
    cyc(8'ha0);
    cyc(8'h0f);
    op(op_toggle_poll);
    chk(rd[10:9], 32'h1);
    op(op_read);
    chk(rd[7:0], 32'hff);
    prot <= 1'b0;
    cyc(8'ha0);
    cyc(8'h00);
    op(op_toggle_poll);
    prot <= 1'b1;
    cyc(8'h30);
    op(op_toggle_poll);
    chk(rd[10:9], 32'h1);
    op(op_read);
    chk(rd[7:0], 32'h00);
    prot <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_program;
    t_data_poll;
    t_fail;
    t_suspend;
    t_protect;
    report_and_stop;
  end
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // tb_flash_host
